// ---- src/cgs_pkg.sv ----
package cgs_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] OFS_OSC_MODE_CTRL   = 4'h0;
    localparam logic [3:0] OFS_INT_OSC_MODE    = 4'h1;
    localparam logic [3:0] OFS_OSC_RUN_CTRL    = 4'h2;
    localparam logic [3:0] OFS_CLK_SELECT      = 4'h3;
    localparam logic [3:0] OFS_SETTLE_STATUS   = 4'h4;
    localparam logic [3:0] OFS_SETTLE_SELECT   = 4'h5;
    localparam logic [3:0] OFS_GEN_STATUS      = 4'h6;

    // field positions, oscillator mode control
    localparam int BIT_EXT_CLK_SEL   = 7;
    localparam int BIT_HS_PIN_MODE   = 6;
    localparam int BIT_SUB_PIN_MODE  = 4;
    // field positions, internal oscillator mode
    localparam int BIT_INT_STOP      = 0;
    localparam int BIT_INT_RUNNING   = 7;
    // field positions, oscillator run control
    localparam int BIT_MAIN_STOP     = 7;
    localparam int BIT_SUB_STOP      = 6;
    // field positions, clock select
    localparam int BIT_MAIN_HS       = 0;
    localparam int BIT_CPU_SUB       = 1;

    // values after reset
    localparam logic [7:0] RST_OSC_MODE_CTRL = 8'h00;
    localparam logic [7:0] RST_OSC_RUN_CTRL  = 8'hC0;
    localparam logic [2:0] RST_SETTLE_SEL    = 3'h4;

    // settle counter layout: stage k is reached at 2^(STAGE_BASE+k) ticks
    localparam int SETTLE_STAGES     = 5;
    localparam int STAGE_BASE        = 11;
    localparam int SETTLE_CNT_W      = STAGE_BASE + SETTLE_STAGES + 1;

    // timing, core clock 100 MHz
    localparam int CORE_CLK_HZ       = 100_000_000;
    localparam int VSET_MIN_US_X100  = 193;     // 1.93 ms least settling
    localparam int VSET_MAX_US_X100  = 539;     // 5.39 ms longest settling
    localparam int REG_SETTLE_US     = 100;     // regulator settling
    localparam int VSET_MIN_CYC      =
        VSET_MIN_US_X100 * (CORE_CLK_HZ / 100_000);
    localparam int REG_SETTLE_CYC    =
        REG_SETTLE_US * (CORE_CLK_HZ / 1_000_000);
    localparam int SETTLE_DIV_CYC    = 1;       // core cycles per settle tick
    localparam int FAST_OSC_KHZ      = 8000;    // nominal internal fast osc

    typedef enum logic [2:0] {
        CGS_POR_HOLD,
        CGS_SETTLE,
        CGS_RUN,
        CGS_STOP,
        CGS_WAKE
    } cgs_state_t;

endpackage : cgs_pkg

// ---- src/cgs_clock_gen.sv ----
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps

module cgs_clock_gen
    import cgs_pkg::*;
#(
    parameter int VSET_CYC   = VSET_MIN_CYC,    // high mode settle cycles
    parameter int REGSET_CYC = REG_SETTLE_CYC   // low mode regulator cycles
) (
    input  wire logic       core_clk,           // 100 MHz core clock
    input  wire logic       rst,                // synchronous reset, high
    input  wire logic       supply_above_low,   // supply over lower threshold
    input  wire logic       supply_above_high,  // supply over higher threshold
    input  wire logic       por_threshold_mode, // option strap, 1 = high mode
    input  wire logic       ext_reset_n,        // external reset pin, low
    input  wire logic       stop_req,           // stop instruction pulse
    input  wire logic       wake_req,           // stop release event
    input  wire logic [3:0] reg_addr,           // register address
    input  wire logic [7:0] reg_wdata,          // register write data
    input  wire logic       reg_wr,             // write strobe
    input  wire logic       reg_rd,             // read strobe
    output logic      [7:0] reg_rdata,          // read data, next cycle
    output logic            internal_reset,     // internal reset held
    output logic            cpu_run,            // cpu clock running
    output logic            int_fast_osc_en,    // internal fast osc enable
    output logic            slow_osc_en,        // internal slow osc enable
    output logic            main_crystal_osc_en,// main crystal osc enable
    output logic            ext_clk_in_en,      // external clock input enable
    output logic            sub_crystal_osc_en, // sub crystal osc enable
    output logic            main_sel_highspeed, // main clock from high-speed
    output logic            cpu_sel_sub,        // cpu clock from subsystem
    output logic            periph_sel_highspeed,// peripheral from high-speed
    output logic            hs_pins_port,       // high-speed pins as ports
    output logic            hs_pins_crystal,    // high-speed pins oscillate
    output logic            hs_pins_ext_clock,  // second pin takes ext clock
    output logic            sub_pins_osc        // sub pins in oscillator mode
);

    cgs_state_t state_reg;
    cgs_state_t state_next;

    logic [7:0]              osc_mode_control_reg;
    logic                    internal_osc_mode_reg;
    logic [7:0]              osc_run_reg;
    logic                    main_hs_reg;
    logic                    cpu_sub_reg;
    logic [2:0]              osc_settle_time_select;
    logic [SETTLE_CNT_W-1:0] settle_cnt_reg;
    logic [31:0]             por_cnt_reg;
    logic [15:0]             div_cnt_reg;
    logic                    settle_tick;
    logic                    core_reset;
    logic                    hold_cond;
    logic                    release_cond;
    logic                    ext_clk_mode;
    logic                    hs_running;
    logic                    cpu_on_fast;
    logic                    cpu_on_hs;
    logic                    settle_done;
    logic [SETTLE_STAGES-1:0] osc_settle_counter_status;

    // reached test for one settle stage, used for status and stop release
    function automatic logic stage_reached(
        input logic [SETTLE_CNT_W-1:0] cnt,
        input logic [2:0]              stage
    );
        logic [SETTLE_CNT_W-1:0] lim;
        lim = '0;
        lim[STAGE_BASE + int'(stage)] = 1'b1;
        return cnt >= lim;
    endfunction : stage_reached

    // supply and pin conditions for reset hold and release
    // supply threshold and reset pin hold
    assign hold_cond    = !supply_above_low || !ext_reset_n;
    assign release_cond = por_threshold_mode ? supply_above_high
                                             : supply_above_low;
    assign core_reset   = rst || (state_reg == CGS_POR_HOLD);

    // decoded clock source view
    assign ext_clk_mode = osc_mode_control_reg[BIT_EXT_CLK_SEL];
    assign hs_running   = !osc_run_reg[BIT_MAIN_STOP];
    assign cpu_on_fast  = !main_hs_reg && !cpu_sub_reg;
    assign cpu_on_hs    = main_hs_reg && !cpu_sub_reg;

    // settle stage selected for stop release
    assign settle_done  = stage_reached(settle_cnt_reg,
                                        osc_settle_time_select);

    // settle status, one bit per elapsed stage
    generate
        for (genvar k = 0; k < SETTLE_STAGES; k++) begin : g_stage
            assign osc_settle_counter_status[k] =
                stage_reached(settle_cnt_reg, 3'(k));
        end
    endgenerate

    // start-up and stop sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CGS_POR_HOLD: begin
                if (!hold_cond && release_cond) begin
                    state_next = CGS_SETTLE;
                end
            end
            CGS_SETTLE: begin
                if (por_threshold_mode) begin
                    if (por_cnt_reg >= 32'(VSET_CYC)) begin
                        state_next = CGS_RUN;
                    end
                end else if (por_cnt_reg >= 32'(REGSET_CYC)) begin
                    state_next = CGS_RUN;
                end
            end
            CGS_RUN: begin
                if (stop_req) begin
                    state_next = CGS_STOP;
                end
            end
            CGS_STOP: begin
                if (wake_req) begin
                    state_next = CGS_WAKE;
                end
            end
            CGS_WAKE: begin
                if (!cpu_on_hs || ext_clk_mode || settle_done) begin
                    state_next = CGS_RUN;
                end
            end
            default: state_next = CGS_POR_HOLD;
        endcase
        if (hold_cond || (state_reg == CGS_POR_HOLD && !release_cond)) begin
            state_next = CGS_POR_HOLD;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= CGS_POR_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // settling timer; high mode counts from the lower threshold crossing
    always_ff @(posedge core_clk) begin
        if (rst || hold_cond) begin
            por_cnt_reg <= '0;
        end else if (state_reg == CGS_POR_HOLD) begin
            por_cnt_reg <= por_threshold_mode ? por_cnt_reg + 32'h1 : '0;
        end else if (state_reg == CGS_SETTLE) begin
            por_cnt_reg <= por_cnt_reg + 32'h1;
        end
    end

    // divider giving the settle counter tick
    always_ff @(posedge core_clk) begin
        if (core_reset || div_cnt_reg >= 16'(SETTLE_DIV_CYC - 1)) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h1;
        end
    end
    assign settle_tick = (div_cnt_reg >= 16'(SETTLE_DIV_CYC - 1));

    // main crystal settle counter, restarts when osc stops or on stop
    // settle progress counter
    always_ff @(posedge core_clk) begin
        if (core_reset || !hs_running || state_reg == CGS_STOP) begin
            settle_cnt_reg <= '0;
        end else if (settle_tick && !settle_cnt_reg[SETTLE_CNT_W-1]) begin
            settle_cnt_reg <= settle_cnt_reg + SETTLE_CNT_W'(1);
        end
    end

    // oscillator mode control register (pin modes)
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            osc_mode_control_reg <= RST_OSC_MODE_CTRL;
        end else if (reg_wr && reg_addr == OFS_OSC_MODE_CTRL) begin
            osc_mode_control_reg <= reg_wdata;
        end
    end

    // internal fast oscillator stop bit; refused while it feeds the cpu
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            internal_osc_mode_reg <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_INT_OSC_MODE) begin
            if (!(cpu_on_fast && reg_wdata[BIT_INT_STOP])) begin
                internal_osc_mode_reg <= reg_wdata[BIT_INT_STOP];
            end
        end
    end

    // main and sub oscillator stop bits
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            osc_run_reg <= RST_OSC_RUN_CTRL;
        end else if (reg_wr && reg_addr == OFS_OSC_RUN_CTRL) begin
            if (!(cpu_on_hs && reg_wdata[BIT_MAIN_STOP])) begin
                osc_run_reg[BIT_MAIN_STOP] <= reg_wdata[BIT_MAIN_STOP];
            end
            if (!(cpu_sub_reg && reg_wdata[BIT_SUB_STOP])) begin
                osc_run_reg[BIT_SUB_STOP] <= reg_wdata[BIT_SUB_STOP];
            end
        end
    end

    // clock source selection, switched only on software command
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            main_hs_reg <= 1'b0;
            cpu_sub_reg <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_CLK_SELECT) begin
            main_hs_reg <= reg_wdata[BIT_MAIN_HS];
            cpu_sub_reg <= reg_wdata[BIT_CPU_SUB];
        end
    end

    // settle time select for stop release
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            osc_settle_time_select <= RST_SETTLE_SEL;
        end else if (reg_wr && reg_addr == OFS_SETTLE_SELECT) begin
            osc_settle_time_select <= (reg_wdata[2:0] < 3'(SETTLE_STAGES))
                                      ? reg_wdata[2:0] : RST_SETTLE_SEL;
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == OFS_OSC_MODE_CTRL) begin
            reg_rdata <= osc_mode_control_reg & 8'hD0;
        end else if (reg_addr == OFS_INT_OSC_MODE) begin
            reg_rdata <= {int_fast_osc_en, 6'h00, internal_osc_mode_reg};
        end else if (reg_addr == OFS_OSC_RUN_CTRL) begin
            reg_rdata <= osc_run_reg & 8'hC0;
        end else if (reg_addr == OFS_CLK_SELECT) begin
            reg_rdata <= {6'h00, cpu_sub_reg, main_hs_reg};
        end else if (reg_addr == OFS_SETTLE_STATUS) begin
            reg_rdata <= {3'h0, osc_settle_counter_status};
        end else if (reg_addr == OFS_SETTLE_SELECT) begin
            reg_rdata <= {5'h00, osc_settle_time_select};
        end else if (reg_addr == OFS_GEN_STATUS) begin
            reg_rdata <= {4'h0, por_threshold_mode, 3'(state_reg)};
        end else begin
            reg_rdata <= '0;
        end
    end

    // reset and cpu clock run outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            internal_reset <= 1'b1;
            cpu_run        <= 1'b0;
        end else begin
            internal_reset <= (state_next == CGS_POR_HOLD);
            cpu_run        <= (state_next == CGS_RUN);
        end
    end

    // oscillator enables
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_fast_osc_en     <= 1'b0;
            slow_osc_en         <= 1'b0;
            main_crystal_osc_en <= 1'b0;
            ext_clk_in_en       <= 1'b0;
            sub_crystal_osc_en  <= 1'b0;
        end else begin
            int_fast_osc_en     <= state_reg != CGS_POR_HOLD
                                   && state_reg != CGS_STOP
                                   && !internal_osc_mode_reg;
            slow_osc_en         <= state_reg != CGS_POR_HOLD;
            main_crystal_osc_en <= hs_running && !ext_clk_mode
                                   && osc_mode_control_reg[BIT_HS_PIN_MODE]
                                   && state_reg != CGS_STOP
                                   && !core_reset;
            ext_clk_in_en       <= hs_running && ext_clk_mode
                                   && osc_mode_control_reg[BIT_HS_PIN_MODE]
                                   && state_reg != CGS_STOP
                                   && !core_reset;
            sub_crystal_osc_en  <= !osc_run_reg[BIT_SUB_STOP]
                                   && osc_mode_control_reg[BIT_SUB_PIN_MODE]
                                   && !core_reset;
        end
    end

    // clock source selects
    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_sel_highspeed   <= 1'b0;
            cpu_sel_sub          <= 1'b0;
            periph_sel_highspeed <= 1'b0;
        end else begin
            main_sel_highspeed   <= main_hs_reg && !core_reset;
            cpu_sel_sub          <= cpu_sub_reg && !core_reset;
            periph_sel_highspeed <= main_hs_reg && !core_reset;
        end
    end

    // pin mode outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hs_pins_port      <= 1'b1;
            hs_pins_crystal   <= 1'b0;
            hs_pins_ext_clock <= 1'b0;
            sub_pins_osc      <= 1'b0;
        end else begin
            hs_pins_port      <= core_reset
                                 || !osc_mode_control_reg[BIT_HS_PIN_MODE];
            hs_pins_crystal   <= !core_reset && !ext_clk_mode
                                 && osc_mode_control_reg[BIT_HS_PIN_MODE];
            hs_pins_ext_clock <= !core_reset && ext_clk_mode
                                 && osc_mode_control_reg[BIT_HS_PIN_MODE];
            sub_pins_osc      <= !core_reset
                                 && osc_mode_control_reg[BIT_SUB_PIN_MODE];
        end
    end

endmodule : cgs_clock_gen

// ---- verif/cgs_clock_gen_chk.sv ----
`timescale 1ns/1ps

module cgs_clock_gen_chk
    import cgs_pkg::*;
#(
    parameter int VSET_CYC   = 50, // high mode settle cycles
    parameter int REGSET_CYC = 20  // low mode regulator cycles
) (
    input wire logic       core_clk,            // core clock
    input wire logic       rst,                 // sync reset
    input wire logic       supply_above_low,    // lower threshold
    input wire logic       supply_above_high,   // higher threshold
    input wire logic       por_threshold_mode,  // threshold strap
    input wire logic       ext_reset_n,         // reset pin
    input wire logic       stop_req,            // stop pulse
    input wire logic [3:0] reg_addr,            // address
    input wire logic [7:0] reg_wdata,           // write data
    input wire logic       reg_wr,              // write strobe
    input wire logic       reg_rd,              // read strobe
    input wire logic [7:0] reg_rdata,           // read data
    input wire logic       internal_reset,      // reset held
    input wire logic       cpu_run,             // cpu running
    input wire logic       int_fast_osc_en,     // fast osc on
    input wire logic       main_crystal_osc_en, // main osc on
    input wire logic       ext_clk_in_en,       // ext clock on
    input wire logic       main_sel_highspeed,  // main from high-speed
    input wire logic       cpu_sel_sub,         // cpu from sub
    input wire logic       hs_pins_crystal,     // pins oscillate
    input wire logic       hs_pins_ext_clock,   // pins take ext clock
    input wire logic       sub_pins_osc         // sub pins oscillate
);
    logic [15:0] rel_cnt; // cycles since supply above lower threshold and reset pin high
    logic [7:0]  wd_q;    // last written data

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // count release time, keep last write data
    always_ff @(posedge core_clk) begin
        if (rst || !supply_above_low || !ext_reset_n) rel_cnt <= 16'h0000;
        else if (rel_cnt != 16'hFFFF) rel_cnt <= rel_cnt + 16'h0001;
        if (reg_wr) wd_q <= reg_wdata;
    end

    AST_RST_HOLD: assert property ($fell(rst) |-> internal_reset && !cpu_run)
        else $error("reset release left cpu running");
    AST_SUPPLY_HOLD: assert property ((!supply_above_low || !ext_reset_n) |=> internal_reset)
        else $error("hold condition did not assert reset");
    AST_HIGH_WAIT: assert property (por_threshold_mode && !supply_above_high && internal_reset |=> internal_reset)
        else $error("reset released below higher threshold");
    AST_START_MIN: assert property ($rose(cpu_run) |-> rel_cnt >= (por_threshold_mode ? VSET_CYC : REGSET_CYC))
        else $error("cpu started before settling");
    AST_START_MAX: assert property (!por_threshold_mode && rel_cnt == REGSET_CYC + 10 |-> cpu_run)
        else $error("cpu late after release");
    AST_FAST_ALIVE: assert property (cpu_run && !main_sel_highspeed && !cpu_sel_sub |-> int_fast_osc_en)
        else $error("cpu source fast osc stopped");
    AST_MAIN_ALIVE: assert property (cpu_run && main_sel_highspeed && !cpu_sel_sub |-> main_crystal_osc_en || ext_clk_in_en)
        else $error("cpu source high-speed stopped");
    AST_STOP_HALT: assert property (cpu_run && stop_req |=> ##1 !cpu_run && !int_fast_osc_en && !main_crystal_osc_en && !ext_clk_in_en)
        else $error("stop did not halt clocks");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_PIN_MODE: assert property (reg_wr && reg_addr == OFS_OSC_MODE_CTRL && cpu_run |=> ##1 hs_pins_ext_clock == (wd_q[7] && wd_q[6]) && hs_pins_crystal == (!wd_q[7] && wd_q[6]) && sub_pins_osc == wd_q[4])
        else $error("pin mode does not follow write");
endmodule : cgs_clock_gen_chk

bind cgs_clock_gen cgs_clock_gen_chk #(.VSET_CYC(VSET_CYC), .REGSET_CYC(REGSET_CYC)) u_chk (
    .core_clk(core_clk), .rst(rst), .supply_above_low(supply_above_low),
    .supply_above_high(supply_above_high), .stop_req(stop_req),
    .por_threshold_mode(por_threshold_mode), .ext_reset_n(ext_reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_reset(internal_reset),
    .cpu_run(cpu_run), .int_fast_osc_en(int_fast_osc_en),
    .main_crystal_osc_en(main_crystal_osc_en), .ext_clk_in_en(ext_clk_in_en),
    .main_sel_highspeed(main_sel_highspeed), .cpu_sel_sub(cpu_sel_sub),
    .hs_pins_crystal(hs_pins_crystal), .hs_pins_ext_clock(hs_pins_ext_clock),
    .sub_pins_osc(sub_pins_osc));

// ---- verif/cgs_supply_model.sv ----
`timescale 1ns/1ps

// supply rail seen by the block, prompt or slow ramp
module cgs_supply_model #(
    parameter int LOW_DLY = 4 // cycles to lower threshold
) (
    input  wire logic core_clk,         // core clock
    input  wire logic power_on,         // rail switched on
    input  wire logic slow_ramp,        // rail rises slowly
    output logic      supply_above_low, // lower threshold crossed
    output logic      supply_above_high // higher threshold crossed
);
    int ramp_cnt; // cycles since rail switched on

    // ramp timer, drops at once when power goes
    always_ff @(posedge core_clk) begin
        if (!power_on) ramp_cnt <= 0;
        else if (ramp_cnt < 1000) ramp_cnt <= ramp_cnt + 1;
    end
    // threshold comparators
    assign supply_above_low  = power_on && ramp_cnt >= LOW_DLY;
    assign supply_above_high = power_on && ramp_cnt >= (slow_ramp ? 120 : 10);
endmodule : cgs_supply_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps

module tb;
    import cgs_pkg::*;
    localparam int VSET   = 50; // shortened high mode settling
    localparam int REGSET = 20; // shortened regulator settling
    logic       core_clk = 1'b0, rst = 1'b1, power_on = 1'b0, slow = 1'b0;
    logic       mode = 1'b0, ext_reset_n = 1'b1, stop_req = 1'b0;
    logic       wake_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic       lo, hi, irst, run, fast, main, ext, sub, mhs, csub, phs;
    logic       pport, pxtal, pext, sosc, slw;
    int         err_total = 0, compares = 0;

    always #5 core_clk = ~core_clk;

    cgs_supply_model u_sup (.core_clk(core_clk), .power_on(power_on),
        .slow_ramp(slow), .supply_above_low(lo), .supply_above_high(hi));
    cgs_clock_gen #(.VSET_CYC(VSET), .REGSET_CYC(REGSET)) DUT (
        .core_clk(core_clk), .rst(rst), .supply_above_low(lo),
        .supply_above_high(hi), .por_threshold_mode(mode),
        .ext_reset_n(ext_reset_n), .stop_req(stop_req), .wake_req(wake_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_reset(irst),
        .cpu_run(run), .int_fast_osc_en(fast), .slow_osc_en(slw),
        .main_crystal_osc_en(main), .ext_clk_in_en(ext),
        .sub_crystal_osc_en(sub), .main_sel_highspeed(mhs),
        .cpu_sel_sub(csub), .periph_sel_highspeed(phs), .hs_pins_port(pport),
        .hs_pins_crystal(pxtal), .hs_pins_ext_clock(pext),
        .sub_pins_osc(sosc));

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
        d = reg_rdata;
    endtask : rd
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, d, e);
    endtask : rdc
    task automatic wait_run(output int n);
        n = 0;
        while (run !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
    endtask : wait_run
    // power down, then ramp; n counts from the lower threshold
    task automatic power_cycle(input logic m, s, output int n);
        power_on <= 1'b0;
        cyc(3);
        mode <= m;
        slow <= s;
        power_on <= 1'b1;
        while (lo !== 1'b1) cyc(1);
        wait_run(n);
    endtask : power_cycle
    task automatic stop_wake(output int n);
        stop_req <= 1'b1;
        cyc(1);
        stop_req <= 1'b0;
        cyc(3);
        chk("stop halt", {run, fast, main, ext}, 4'h0);
        wake_req <= 1'b1;
        cyc(1);
        wake_req <= 1'b0;
        wait_run(n);
    endtask : stop_wake

    task automatic t_low_start();
        int n;
        chk("held before power", {irst, run, slw}, 3'b100);
        power_cycle(1'b0, 1'b0, n);
        chk("low start time", n >= REGSET && n <= REGSET + 8, 1);
        chk("fast osc on", {fast, slw}, 2'b11);
        chk("cpu on fast", {mhs, csub, phs}, 3'b000);
        chk("crystals idle", {main, sub, ext}, 3'b000);
        chk("pins port", {pport, pxtal, pext, sosc}, 4'b1000);
        rdc(OFS_OSC_MODE_CTRL, RST_OSC_MODE_CTRL, "mode ctrl");
        rdc(OFS_OSC_RUN_CTRL, RST_OSC_RUN_CTRL, "run ctrl");
        rdc(OFS_CLK_SELECT, 8'h00, "clk select");
        rdc(OFS_SETTLE_SELECT, {5'h00, RST_SETTLE_SEL}, "settle sel");
        rdc(4'hF, 8'h00, "unmapped");
        $display("test low_start done");
    endtask : t_low_start

    task automatic t_ext_reset();
        int n;
        wr(OFS_OSC_MODE_CTRL, 8'h10);
        ext_reset_n <= 1'b0;
        cyc(5);
        chk("pin reset hold", {irst, run}, 2'b10);
        ext_reset_n <= 1'b1;
        wait_run(n);
        chk("pin reset restart", n >= REGSET && n <= REGSET + 8, 1);
        chk("restart on fast", {fast, mhs, sosc}, 3'b100);
        $display("test ext_reset done");
    endtask : t_ext_reset

    task automatic t_main();
        int n;
        logic [7:0] d;
        wr(OFS_OSC_MODE_CTRL, 8'h40);
        cyc(2);
        chk("crystal pins", {pport, pxtal, pext, sosc}, 4'b0100);
        wr(OFS_OSC_RUN_CTRL, 8'h40);
        rdc(OFS_SETTLE_STATUS, 8'h00, "settle early");
        n = 2;
        d = 8'h00;
        while (d[0] !== 1'b1 && n < 3000) begin
            rd(OFS_SETTLE_STATUS, d);
            n += 2;
        end
        chk("settle stage time", n >= 2040 && n <= 2064, 1);
        chk("main osc on", main, 1'b1);
        wr(OFS_CLK_SELECT, 8'h01);
        wr(OFS_INT_OSC_MODE, 8'h01);
        cyc(2);
        chk("cpu on main", {mhs, phs, fast}, 3'b110);
        rdc(OFS_INT_OSC_MODE, 8'h01, "fast osc state");
        wr(OFS_SETTLE_SELECT, 8'h07);
        rdc(OFS_SETTLE_SELECT, 8'h04, "settle clamp");
        wr(OFS_SETTLE_SELECT, 8'h00);
        wr(OFS_OSC_RUN_CTRL, 8'hC0);
        cyc(2);
        chk("source stop refused", main, 1'b1);
        stop_wake(n);
        chk("wake settle time", n >= 2040 && n <= 2070, 1);
        $display("test main done");
    endtask : t_main

    task automatic t_ext_clock();
        int n;
        power_cycle(1'b0, 1'b0, n);
        wr(OFS_OSC_MODE_CTRL, 8'hD0);
        wr(OFS_OSC_RUN_CTRL, 8'h00);
        cyc(2);
        chk("ext pins", {pport, pxtal, pext, sosc, ext, main, sub},
            7'b0011101);
        wr(OFS_CLK_SELECT, 8'h01);
        stop_wake(n);
        chk("ext no settle", n <= 8, 1);
        wr(OFS_CLK_SELECT, 8'h02);
        wr(OFS_OSC_RUN_CTRL, 8'hC0);
        rdc(OFS_OSC_RUN_CTRL, 8'h80, "sub stop refused");
        wr(OFS_OSC_MODE_CTRL, 8'h00);
        cyc(2);
        chk("pins freed", {pport, ext, sub, sosc}, 4'b1000);
        $display("test ext_clock done");
    endtask : t_ext_clock

    task automatic t_high_start();
        int n;
        int lo_lim;
        for (int s = 1; s >= 0; s--) begin
            power_cycle(1'b1, s[0], n);
            lo_lim = s ? 116 : VSET;
            chk("high start time", n >= lo_lim && n <= lo_lim + 8, 1);
            chk("high start fast", {fast, mhs}, 2'b10);
            rdc(OFS_GEN_STATUS, 8'h0A, "strap status");
        end
        $display("test high_start done");
    endtask : t_high_start

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    initial begin
        cyc(2);
        rst <= 1'b0;
        t_low_start();
        t_ext_reset();
        t_main();
        t_ext_clock();
        t_high_start();
        final_report();
    end
    // watchdog against a hang
    initial begin
        cyc(20000);
        err_total++;
        final_report();
    end
endmodule : tb
